// >>> scr_setup_ctrl.sv
`timescale 1ns/1ns
// Operation
// - Mode selector picks one of five bus modes
// - Single bus enable bit, resets disabled
// - Per-pin data bit drives output, reads pin
// - Two plain 32-bit scratch storage registers
// - Wait limit exceeded sets FIFO error flag
// - Code Fh stalls write until room
// - Interrupt only when enable and flag set
// - FIFO error flag readable, one when pending
// - Writing one to acknowledge clears flag
// - Snoop enable exposes palette register accesses
// - Read ready delay one adds one clock
module scr_setup_ctrl
  import scr_pkg::*;
(
  input wire logic clk_i,               // Core clock, 25 MHz.
  input wire logic resetn_i,            // Chip reset, active low, async.
  input wire logic [7:0] reg_addr_i,    // Register word offset.
  input wire logic reg_wr_i,            // Register write strobe.
  input wire logic reg_rd_i,            // Register read strobe.
  input wire logic [31:0] reg_wdata_i,  // Register write data.
  output logic [31:0] reg_rdata_o,      // Register read data.
  output logic reg_rvalid_o,            // Read data valid pulse.
  input wire logic [15:0] gpio_pin_i,   // Pin levels from the pads.
  output logic [15:0] gpio_pin_o,       // Pin drive values.
  output logic [15:0] gpio_pin_oe_o,    // Pin drive enables.
  output logic [2:0] io_bus_mode_select_o, // Active bus mode.
  output logic io_bus_enable_o,         // Bus enabled.
  input wire logic cmd_wr_i,            // Host write into command FIFO.
  input wire logic fifo_full_i,         // Command FIFO full.
  output logic cmd_push_o,              // Push into command FIFO.
  output logic cmd_wait_o,              // Host write held off.
  input wire logic host_data_err_i,     // Host data error pulse.
  output logic irq_o,                   // Error interrupt request.
  input wire logic palette_access_i,    // Host touched palette registers.
  output logic palette_snoop_o,         // Palette access seen on host bus.
  output logic read_ready_delay_o       // Delay memory read ready.
);

  logic rst_meta_reg;
  logic rst_n_reg;
  logic [15:0] pin_meta_reg;
  logic [15:0] pin_sync_reg;
  logic [31:0] gbc_reg;
  logic [31:0] gpd_reg;
  logic [31:0] scratch0_reg;
  logic [31:0] scratch1_reg;
  logic [31:0] bic_reg;
  logic fifo_err_reg;
  logic host_err_reg;
  logic fw_err;
  logic fw_wait;
  logic fw_push;
  logic [31:0] rdata_next;

  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = reg_wr_i && (reg_addr_i == off);
  endfunction

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // Pads are asynchronous to the core clock.
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pin_meta_reg <= 16'h0000;
      pin_sync_reg <= 16'h0000;
    end else begin
      pin_meta_reg <= gpio_pin_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      gbc_reg <= SCR_GBC_RESET;
    end else if (wr_hit(SCR_OFF_GPIO_BUS_CONTROL)) begin
      gbc_reg <= 32'h0000_0000;
      gbc_reg[SCR_GBC_MODE_LSB +: 3] <=
        reg_wdata_i[SCR_GBC_MODE_LSB +: 3];
      gbc_reg[SCR_GBC_ENABLE_BIT] <= reg_wdata_i[SCR_GBC_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      gpd_reg <= SCR_GPD_RESET;
    end else if (wr_hit(SCR_OFF_GPIO_PIN_DATA_DIRECTION)) begin
      gpd_reg <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      scratch0_reg <= SCR_SCRATCH_RESET;
      scratch1_reg <= SCR_SCRATCH_RESET;
    end else begin
      if (wr_hit(SCR_OFF_SCRATCH_PAD_ZERO)) begin
        scratch0_reg <= reg_wdata_i;
      end
      if (wr_hit(SCR_OFF_SCRATCH_PAD_ONE)) begin
        scratch1_reg <= reg_wdata_i;
      end
    end
  end

  // Flag and acknowledge bits are held apart from the stored fields.
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bic_reg <= SCR_BIC_RESET;
    end else if (wr_hit(SCR_OFF_BUS_INTERFACE_CONTROL)) begin
      bic_reg <= reg_wdata_i & SCR_BIC_STORE_MASK;
      bic_reg[SCR_BIC_PALETTE_SNOOP_BIT] <=
        reg_wdata_i[SCR_BIC_PALETTE_SNOOP_BIT];
      bic_reg[SCR_BIC_FIFO_ERR_EN_BIT] <=
        reg_wdata_i[SCR_BIC_FIFO_ERR_EN_BIT];
      bic_reg[SCR_BIC_HOST_ERR_EN_BIT] <=
        reg_wdata_i[SCR_BIC_HOST_ERR_EN_BIT];
      // Code zero is reserved; the bit is kept as written.
      bic_reg[SCR_BIC_READ_DELAY_BIT] <=
        reg_wdata_i[SCR_BIC_READ_DELAY_BIT];
    end
  end

  // A new error in the acknowledge cycle stays pending.
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fifo_err_reg <= 1'b0;
      host_err_reg <= 1'b0;
    end else begin
      fifo_err_reg <= (fifo_err_reg &
        ~(wr_hit(SCR_OFF_BUS_INTERFACE_CONTROL) &
          reg_wdata_i[SCR_BIC_FIFO_ERR_BIT])) | fw_err;
      host_err_reg <= (host_err_reg &
        ~(wr_hit(SCR_OFF_BUS_INTERFACE_CONTROL) &
          reg_wdata_i[SCR_BIC_HOST_ERR_BIT])) | host_data_err_i;
    end
  end

  scr_fifo_wait u_fifo_wait (
    .clk_i(clk_i),
    .rst_n_i(rst_n_reg),
    .wr_req_i(cmd_wr_i),
    .fifo_full_i(fifo_full_i),
    .limit_i(bic_reg[SCR_BIC_FIFO_WAIT_LSB +: 4]),
    .push_o(fw_push),
    .wait_o(fw_wait),
    .err_o(fw_err)
  );

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (reg_addr_i)
      SCR_OFF_GPIO_BUS_CONTROL: rdata_next = gbc_reg;
      SCR_OFF_GPIO_PIN_DATA_DIRECTION: begin
        rdata_next[SCR_GPD_DATA_LSB +: 16] = pin_sync_reg;
        rdata_next[SCR_GPD_DIR_LSB +: 16] = gpd_reg[SCR_GPD_DIR_LSB +: 16];
      end
      SCR_OFF_SCRATCH_PAD_ZERO: rdata_next = scratch0_reg;
      SCR_OFF_SCRATCH_PAD_ONE: rdata_next = scratch1_reg;
      SCR_OFF_BUS_INTERFACE_CONTROL: begin
        rdata_next = bic_reg;
        rdata_next[SCR_BIC_FIFO_ERR_BIT] = fifo_err_reg;
        rdata_next[SCR_BIC_HOST_ERR_BIT] = host_err_reg;
      end
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      reg_rdata_o <= 32'h0000_0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_next;
      end
    end
  end

  // Pins are released whenever the bus is disabled.
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      gpio_pin_o <= 16'h0000;
      gpio_pin_oe_o <= 16'h0000;
      io_bus_mode_select_o <= SCR_MODE_VIDEO_PORT;
      io_bus_enable_o <= 1'b0;
    end else begin
      gpio_pin_o <= gpd_reg[SCR_GPD_DATA_LSB +: 16];
      gpio_pin_oe_o <= gpd_reg[SCR_GPD_DIR_LSB +: 16] &
        {16{gbc_reg[SCR_GBC_ENABLE_BIT]}};
      io_bus_mode_select_o <= gbc_reg[SCR_GBC_MODE_LSB +: 3];
      io_bus_enable_o <= gbc_reg[SCR_GBC_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cmd_push_o <= 1'b0;
      cmd_wait_o <= 1'b0;
      irq_o <= 1'b0;
      palette_snoop_o <= 1'b0;
      read_ready_delay_o <= 1'b0;
    end else begin
      cmd_push_o <= fw_push;
      cmd_wait_o <= fw_wait;
      irq_o <= (fifo_err_reg & bic_reg[SCR_BIC_FIFO_ERR_EN_BIT]) |
        (host_err_reg & bic_reg[SCR_BIC_HOST_ERR_EN_BIT]);
      palette_snoop_o <= palette_access_i &
        bic_reg[SCR_BIC_PALETTE_SNOOP_BIT];
      read_ready_delay_o <= bic_reg[SCR_BIC_READ_DELAY_BIT];
    end
  end

endmodule

// >>> scr_pkg.sv
package scr_pkg;

  // Register word offsets on the register port (DWORD index).
  localparam logic [7:0] SCR_OFF_GPIO_BUS_CONTROL = 8'h1E;
  localparam logic [7:0] SCR_OFF_GPIO_PIN_DATA_DIRECTION = 8'h1F;
  localparam logic [7:0] SCR_OFF_SCRATCH_PAD_ZERO = 8'h20;
  localparam logic [7:0] SCR_OFF_SCRATCH_PAD_ONE = 8'h21;
  localparam logic [7:0] SCR_OFF_BUS_INTERFACE_CONTROL = 8'h28;

  // Bus mode selector codes.
  localparam logic [2:0] SCR_MODE_VIDEO_PORT = 3'h0;
  localparam logic [2:0] SCR_MODE_VIDEO_MEMORY_CONTROLLER = 3'h1;
  localparam logic [2:0] SCR_MODE_FEATURE_CONNECTOR = 3'h2;
  localparam logic [2:0] SCR_MODE_ENGINE_DIAGNOSTIC = 3'h3;
  localparam logic [2:0] SCR_MODE_GENERAL_PIN = 3'h4;

  // gpio_bus_control fields.
  localparam int SCR_GBC_MODE_LSB = 0;
  localparam int SCR_GBC_ENABLE_BIT = 3;

  // gpio_pin_data_direction fields.
  localparam int SCR_GPIO_PINS = 16;
  localparam int SCR_GPD_DATA_LSB = 0;
  localparam int SCR_GPD_DIR_LSB = 16;

  // bus_interface_control fields.
  localparam int SCR_BIC_PALETTE_SNOOP_BIT = 13;
  localparam int SCR_BIC_FIFO_WAIT_LSB = 16;
  localparam int SCR_BIC_FIFO_ERR_EN_BIT = 20;
  localparam int SCR_BIC_FIFO_ERR_BIT = 21;
  localparam int SCR_BIC_HOST_ERR_EN_BIT = 22;
  localparam int SCR_BIC_HOST_ERR_BIT = 23;
  localparam int SCR_BIC_READ_DELAY_BIT = 31;

  // Stored bits of bus_interface_control (only the wait limit bits 19:16 have effect in this block).
  localparam logic [31:0] SCR_BIC_STORE_MASK = 32'h700F_DFFF;

  // Reset values.
  localparam logic [31:0] SCR_BIC_RESET = 32'h800F_00FF;
  localparam logic [31:0] SCR_GBC_RESET = 32'h0000_0000;
  localparam logic [31:0] SCR_GPD_RESET = 32'h0000_0000;
  localparam logic [31:0] SCR_SCRATCH_RESET = 32'h0000_0000;

  // Wait limit code that means stall until the FIFO has room.
  localparam logic [3:0] SCR_FIFO_WAIT_FOREVER = 4'hF;

  typedef enum logic {
    SCR_FW_IDLE,
    SCR_FW_WAIT
  } scr_fw_state_type;

endpackage

// >>> scr_fifo_wait.sv
`timescale 1ns/1ns
module scr_fifo_wait
  import scr_pkg::*;
(
  input wire logic clk_i,          // Core clock.
  input wire logic rst_n_i,        // Synchronised reset, active low.
  input wire logic wr_req_i,       // One-cycle host write into the FIFO.
  input wire logic fifo_full_i,    // Command FIFO is full.
  input wire logic [3:0] limit_i,  // Wait-state limit code.
  output logic push_o,             // One-cycle push into the FIFO.
  output logic wait_o,             // Host write is being held off.
  output logic err_o               // One-cycle wait-limit error.
);

  scr_fw_state_type state_reg;
  logic [3:0] count_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SCR_FW_IDLE;
      count_reg <= 4'h0;
      push_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      push_o <= 1'b0;
      err_o <= 1'b0;
      unique case (state_reg)
        SCR_FW_IDLE: begin
          count_reg <= 4'h0;
          if (wr_req_i) begin
            if (!fifo_full_i) begin
              push_o <= 1'b1;
            end else begin
              state_reg <= SCR_FW_WAIT;
            end
          end
        end
        SCR_FW_WAIT: begin
          if (!fifo_full_i) begin
            push_o <= 1'b1;
            state_reg <= SCR_FW_IDLE;
          end else if (limit_i != SCR_FIFO_WAIT_FOREVER &&
                       count_reg >= limit_i) begin
            // The write is dropped; software learns of it via the flag.
            err_o <= 1'b1;
            state_reg <= SCR_FW_IDLE;
          end else if (count_reg != 4'hF) begin
            count_reg <= count_reg + 4'h1;
          end
        end
      endcase
    end
  end

  assign wait_o = (state_reg == SCR_FW_WAIT);

endmodule

// >>> scr_setup_ctrl_sva.sv
`timescale 1ns/1ns
module scr_setup_ctrl_sva (
  input wire logic clk_i,                     // Core clock.
  input wire logic resetn_i,                  // Chip reset, active low.
  input wire logic reg_wr_i,                  // Write strobe.
  input wire logic reg_rd_i,                  // Read strobe.
  input wire logic reg_rvalid_o,              // Read valid.
  input wire logic [15:0] gpio_pin_oe_o,      // Pin enables.
  input wire logic [2:0] io_bus_mode_select_o, // Bus mode.
  input wire logic io_bus_enable_o,           // Bus enable.
  input wire logic cmd_wr_i,                  // FIFO write.
  input wire logic fifo_full_i,               // FIFO full.
  input wire logic cmd_push_o,                // FIFO push.
  input wire logic cmd_wait_o,                // Host held off.
  input wire logic palette_access_i,          // Palette access.
  input wire logic palette_snoop_o            // Snooped access.
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  rd_answer_a: assert property (
    reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  rvalid_cause_a: assert property (
    reg_rvalid_o |-> $past(reg_rd_i)) else $error("valid without read");
  oe_enable_a: assert property (
    |gpio_pin_oe_o |-> io_bus_enable_o) else $error("drive while off");
  oe_write_a: assert property (
    $changed(gpio_pin_oe_o) |-> $past(reg_wr_i, 2))
    else $error("enables moved alone");
  mode_write_a: assert property (
    $changed(io_bus_mode_select_o) |-> $past(reg_wr_i, 2))
    else $error("mode moved alone");
  wr_push_a: assert property (
    cmd_wr_i && !fifo_full_i && !cmd_wait_o |-> ##2 cmd_push_o)
    else $error("write not pushed");
  push_room_a: assert property (
    cmd_push_o |-> !$past(fifo_full_i, 2)) else $error("push into full");
  snoop_cause_a: assert property (
    palette_snoop_o |-> $past(palette_access_i))
    else $error("snoop without access");
endmodule

// >>> scr_pad_model.sv
`timescale 1ns/1ns
// Pads: a pin shows the block's value only while it is driven.
module scr_pad_model (
  input wire logic [15:0] drive_i,   // Block drive values.
  input wire logic [15:0] enable_i,  // Block drive enables.
  input wire logic [15:0] float_i,   // Far side level, changed per test.
  output logic [15:0] level_o        // Pad levels.
);
  assign level_o = drive_i & enable_i | float_i & ~enable_i;
endmodule

// >>> scr_setup_ctrl_bench.sv
`timescale 1ns/1ns
module scr_setup_ctrl_bench import scr_pkg::*;;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic [31:0] reg_rdata_o, d, e, r;
  logic [15:0] gpio_pin_i, gpio_pin_o, gpio_pin_oe_o, oe;
  logic [15:0] pad_ext = 16'h0000;
  logic [2:0] io_bus_mode_select_o;
  logic reg_rvalid_o, io_bus_enable_o, cmd_push_o, cmd_wait_o, irq_o;
  logic palette_snoop_o, read_ready_delay_o, en;
  logic cmd_wr_i = 1'b0;
  logic fifo_full_i = 1'b0;
  logic host_data_err_i = 1'b0;
  logic palette_access_i = 1'b0;
  int miscompares = 0;
  int tests_run = 0;
  logic [7:0] ra [6] = '{8'h28, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h05};
  scr_setup_ctrl DUT (.*);
  scr_pad_model pads (.drive_i(gpio_pin_o), .enable_i(gpio_pin_oe_o),
    .float_i(pad_ext), .level_o(gpio_pin_i));
  initial forever #20 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk(32'(reg_rvalid_o), 32'h1);
    r = reg_rdata_o;
  endtask
  task automatic pulse_cmd(input logic full);
    @(negedge clk_i);
    fifo_full_i = full;
    cmd_wr_i = 1'b1;
    @(negedge clk_i);
    cmd_wr_i = 1'b0;
  endtask
  task automatic irq_after(input logic [31:0] v, input logic exp);
    wr(8'h28, v);
    repeat (3) @(negedge clk_i);
    chk(32'(irq_o), 32'(exp));
  endtask
  // Sets the wait limit and keeps the other stored fields at reset value so only the bits in m move.
  function automatic logic [31:0] bic(input logic [3:0] lim,
    input logic [31:0] m);
    return 32'h8000_00FF | {12'h000, lim, 16'h0000} | m;
  endfunction
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(40 * 4000);
    miscompares++;
    final_report();
  end
  initial begin
    void'($urandom(32'h8d50_76f1));
    repeat (8) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(32'(read_ready_delay_o), 32'h1);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(r, ra[i] == 8'h28 ? SCR_BIC_RESET : 32'h0000_0000);
    end
    d = $urandom;
    e = $urandom;
    wr(8'h20, d);
    wr(8'h21, e);
    rd(8'h20);
    chk(r, d);
    rd(8'h21);
    chk(r, e);
    for (int m = 0; m < 5; m++) begin
      d = $urandom;
      pad_ext = 16'($urandom);
      en = m[0] | m[2];
      wr(8'h1E, {28'h000_0000, en, m[2:0]});
      wr(8'h1F, d);
      // Four cycles cover the output flop and the two pad synchronisers.
      repeat (4) @(negedge clk_i);
      oe = d[31:16] & {16{en}};
      chk(32'(io_bus_mode_select_o), 32'(m));
      chk(32'(io_bus_enable_o), 32'(en));
      chk(32'(gpio_pin_oe_o), 32'(oe));
      chk(32'(gpio_pin_o), 32'(d[15:0]));
      rd(8'h1F);
      chk(r, {d[31:16], d[15:0] & oe | pad_ext & ~oe});
    end
    pulse_cmd(1'b0);
    @(negedge clk_i);
    chk(32'(cmd_push_o), 32'h1);
    pulse_cmd(1'b1);
    repeat (6) @(negedge clk_i);
    chk(32'(cmd_wait_o), 32'h1);
    fifo_full_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(32'(cmd_push_o), 32'h1);
    rd(8'h28);
    chk(r, SCR_BIC_RESET);
    wr(8'h28, bic(4'h2, 32'h0));
    pulse_cmd(1'b1);
    repeat (12) @(negedge clk_i);
    chk(32'(cmd_wait_o), 32'h0);
    fifo_full_i = 1'b0;
    rd(8'h28);
    chk(r, bic(4'h2, 32'h0020_0000));
    chk(32'(irq_o), 32'h0);
    irq_after(bic(4'h2, 32'h0010_0000), 1'b1);
    irq_after(bic(4'h2, 32'h0030_0000), 1'b0);
    rd(8'h28);
    chk(r, bic(4'h2, 32'h0010_0000));
    @(negedge clk_i);
    host_data_err_i = 1'b1;
    @(negedge clk_i);
    host_data_err_i = 1'b0;
    rd(8'h28);
    chk(r, bic(4'h2, 32'h0090_0000));
    irq_after(bic(4'h2, 32'h0050_0000), 1'b1);
    irq_after(bic(4'h2, 32'h00D0_0000), 1'b0);
    for (int s = 0; s < 2; s++) begin
      wr(8'h28, bic(4'hF, 32'(s) << 13));
      @(negedge clk_i);
      palette_access_i = 1'b1;
      @(negedge clk_i);
      palette_access_i = 1'b0;
      chk(32'(palette_snoop_o), 32'(s));
    end
    final_report();
  end
endmodule
bind scr_setup_ctrl scr_setup_ctrl_sva u_sva (.*);
